//--- include/lfp_pkg.sv
// Constants and carrier types for the LED fault and phase register slice
package lfp_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned DATA_W  = 13;
   localparam int unsigned FLAG_W  = 6;
   localparam int unsigned PHASE_W = 8;
   localparam int unsigned GRP_W   = 2;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_OPEN_LED   = 8'h0f;
   localparam logic [ADDR_W-1:0] OFS_OPEN_TRACE = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_GRP_PHASE  = 8'h11;
   localparam logic [ADDR_W-1:0] OFS_DRV0_PHASE = 8'h12;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned FLAG_LSB    = 0;
   localparam int unsigned PHASE_LSB   = 0;
   localparam int unsigned GRP_SEL_LSB = 8;
   localparam int unsigned GRP_A_BIT   = 0;
   localparam int unsigned GRP_B_BIT   = 1;

   // ----------------------------------------------------------------
   // Reset values and the no-group select code
   // ----------------------------------------------------------------
   localparam logic [FLAG_W-1:0]  FLAG_RST        = 6'h00;
   localparam logic [GRP_W-1:0]   GRP_SEL_RST     = 2'h1;
   localparam logic [GRP_W-1:0]   GRP_SEL_NONE    = 2'h0;
   localparam logic [PHASE_W-1:0] BCAST_PHASE_RST = 8'h00;
   localparam logic [PHASE_W-1:0] DRV0_PHASE_RST  = 8'h00;
   localparam logic [DATA_W-1:0]  RDATA_RST       = 13'h0000;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } lfp_reg_req_s;

   typedef struct packed {
      logic [GRP_W-1:0]   grp;
      logic [PHASE_W-1:0] phase;
   } lfp_bcast_s;

endpackage

//--- sim/testbench.sv
// Self-checking bench for the LED fault and phase register slice
`timescale 1ns/10ps
`default_nettype none

module testbench;
   logic                  mclk;
   logic                  rst_b;
   lfp_pkg::lfp_reg_req_s req;
   logic [12:0]           rdata;
   logic                  rvalid;
   logic [5:0]            led_det;
   logic [5:0]            trc_det;
   logic                  grp_a;
   logic                  grp_b;
   logic [5:0]            led_f;
   logic [5:0]            trc_f;
   logic [7:0]            drv0;
   logic                  bc_valid;
   lfp_pkg::lfp_bcast_s   bc;
   logic [7:0]            ph;
   logic [7:0]            exp_ph;
   logic [5:0]            chan;
   int                    errors = 0;
   int                    check_count = 0;
   int                    cycles = 0;

   lfp_led_fault_phase_regs DUT (
      .mclk                 (mclk),
      .rst_b                (rst_b),
      .reg_req              (req),
      .reg_rdata            (rdata),
      .reg_rvalid           (rvalid),
      .open_led_detect      (led_det),
      .open_trace_detect    (trc_det),
      .group_a_assignment   (grp_a),
      .group_b_assignment   (grp_b),
      .open_led_flag_bits   (led_f),
      .open_trace_flag_bits (trc_f),
      .driver0_phase_select (drv0),
      .bcast_valid          (bc_valid),
      .bcast                (bc)
   );

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // ----------------------------------------------------------------
   // Checking and access tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check_word(input string n, input logic [12:0] e,
                             input logic [12:0] g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic check_bit(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask

   // Strobes stay up after an access; the next access or detect drops
   // them, so no strobe is written twice in one time step
   task automatic reg_write(input logic [7:0] a, input logic [12:0] d);
      req.wr = 1'b1;
      req.rd = 1'b0;
      req.addr = a;
      req.wdata = d;
      @(posedge mclk);
      #2;
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [12:0] e);
      req.wr = 1'b0;
      req.rd = 1'b1;
      req.addr = a;
      @(posedge mclk);
      #2;
      check_bit("rvalid", 1'b1, rvalid);
      check_word("rdata", e, rdata);
   endtask

   task automatic detect(input logic [5:0] l, input logic [5:0] t);
      req.wr = 1'b0;
      req.rd = 1'b0;
      led_det = l;
      trc_det = t;
      @(posedge mclk);
      #2;
      led_det = 6'h00;
      trc_det = 6'h00;
   endtask

   // Hang guard, generous against about 93 cycles of tests
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         errors++;
         $display("mismatch timeout expected 0 seen %0d", cycles);
         complete_run();
      end
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      rst_b = 1'b0;
      req = '0;
      led_det = 6'h00;
      trc_det = 6'h00;
      grp_a = 1'b0;
      grp_b = 1'b0;
      repeat (6) @(posedge mclk);
      #2;
      rst_b = 1'b1;
      @(posedge mclk);
      #2;
      check_word("led port", 13'h0000, {7'h00, led_f});
      check_word("drv0 port", 13'h0000, {5'h00, drv0});
      check_bit("bc idle", 1'b0, bc_valid);
      reg_read(lfp_pkg::OFS_OPEN_LED, 13'h0000);
      reg_read(lfp_pkg::OFS_OPEN_TRACE, 13'h0000);
      reg_read(lfp_pkg::OFS_GRP_PHASE, 13'h0100);
      reg_read(lfp_pkg::OFS_DRV0_PHASE, 13'h0000);
      reg_read(8'h20, 13'h0000);
      $display("test reset values done");
      detect(6'h2a, 6'h15);
      reg_read(lfp_pkg::OFS_OPEN_LED, 13'h002a);
      reg_read(lfp_pkg::OFS_OPEN_TRACE, 13'h0015);
      reg_write(lfp_pkg::OFS_OPEN_LED, 13'h0000);
      reg_read(lfp_pkg::OFS_OPEN_LED, 13'h002a);
      reg_write(lfp_pkg::OFS_OPEN_LED, 13'h0002);
      reg_read(lfp_pkg::OFS_OPEN_LED, 13'h0028);
      led_det = 6'h08;
      reg_write(lfp_pkg::OFS_OPEN_LED, 13'h0008);
      led_det = 6'h00;
      reg_read(lfp_pkg::OFS_OPEN_LED, 13'h0028);
      reg_write(lfp_pkg::OFS_OPEN_LED, 13'h1fff);
      reg_write(lfp_pkg::OFS_OPEN_TRACE, 13'h003f);
      reg_read(lfp_pkg::OFS_OPEN_TRACE, 13'h0000);
      for (int i = 0; i < 6; i++)
      begin
         chan = 6'h01 << i;
         detect(chan, ~chan);
         check_word("led ch", {7'h00, chan}, {7'h00, led_f});
         check_word("trc ch", {7'h00, ~chan}, {7'h00, trc_f});
         reg_write(lfp_pkg::OFS_OPEN_LED, {7'h00, chan});
         reg_write(lfp_pkg::OFS_OPEN_TRACE, {7'h00, ~chan});
         check_word("led clr", 13'h0000, {7'h00, led_f});
         check_word("trc clr", 13'h0000, {7'h00, trc_f});
      end
      $display("test fault flags done");
      // Every select code against every membership of driver 0
      for (int s = 0; s < 4; s++)
      begin
         for (int m = 0; m < 4; m++)
         begin
            ph = 8'h81 + 8'(s * 16 + m);
            {grp_b, grp_a} = 2'(m);
            reg_write(lfp_pkg::OFS_DRV0_PHASE, 13'h005a);
            reg_write(lfp_pkg::OFS_GRP_PHASE, {3'h0, 2'(s), ph});
            check_bit("bc valid", s != 0, bc_valid);
            exp_ph = ((s & m) != 0) ? ph : 8'h5a;
            check_word("drv0", {5'h00, exp_ph}, {5'h00, drv0});
            if (s != 0)
               check_word("bc", {3'h0, 2'(s), ph}, {3'h0, bc});
            reg_read(lfp_pkg::OFS_GRP_PHASE, {3'h0, 2'(s), ph});
            check_bit("bc drop", 1'b0, bc_valid);
         end
      end
      $display("test group broadcast done");
      reg_write(lfp_pkg::OFS_DRV0_PHASE, 13'h1fff);
      reg_read(lfp_pkg::OFS_DRV0_PHASE, 13'h00ff);
      reg_read(lfp_pkg::OFS_DRV0_PHASE, 13'h00ff);
      $display("test driver 0 phase done");
      complete_run();
   end
endmodule

`default_nettype wire

//--- verilog/lfp_flag_bank.sv
// Sticky fault flags, set by detection, cleared by writing ones
`timescale 1ns/10ps
`default_nettype none

module lfp_flag_bank #(
   parameter int unsigned W = 6
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] detect,
   input  wire logic         clear_en,
   input  wire logic [W-1:0] clear_mask,
   output logic      [W-1:0] flags
);

   logic [W-1:0] flags_reg;
   logic [W-1:0] flags_next;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Set term applied last so a detection beats a same-cycle clear
   always_comb
   begin
      flags_next = flags_reg;
      if (clear_en)
      begin
         flags_next = flags_next & ~clear_mask;
      end
      flags_next = flags_next | detect;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         flags_reg <= W'(lfp_pkg::FLAG_RST);
      end
      else
      begin
         flags_reg <= flags_next;
      end
   end

   assign flags = flags_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   chk_flag_sticky: assert property (
      (|(flags & ~(clear_mask & {W{clear_en}})))
      |=> ((flags & $past(flags & ~(clear_mask & {W{clear_en}})))
           == $past(flags & ~(clear_mask & {W{clear_en}}))))
      else $error("flag dropped without a clearing one");

   chk_flag_set_wins: assert property (
      (|detect) |=> ((flags & $past(detect)) == $past(detect)))
      else $error("detection lost");

   chk_flag_clear: assert property (
      (clear_en && (|(clear_mask & ~detect)))
      |=> ((flags & $past(clear_mask & ~detect)) == '0))
      else $error("write one did not clear flag");

   chk_flag_no_spurious: assert property (
      ((flags == '0) && (detect == '0)) |=> (flags == '0))
      else $error("flag set without detection");

endmodule

`default_nettype wire

//--- verilog/lfp_led_fault_phase_regs.sv
// Open-LED and open-trace flags, group phase broadcast, driver 0 phase
`timescale 1ns/10ps
`default_nettype none

module lfp_led_fault_phase_regs (
   input  wire logic                        mclk,
   input  wire logic                        rst_b,
   input  wire lfp_pkg::lfp_reg_req_s       reg_req,
   output logic [lfp_pkg::DATA_W-1:0]       reg_rdata,
   output logic                             reg_rvalid,
   input  wire logic [lfp_pkg::FLAG_W-1:0]  open_led_detect,
   input  wire logic [lfp_pkg::FLAG_W-1:0]  open_trace_detect,
   input  wire logic                        group_a_assignment,
   input  wire logic                        group_b_assignment,
   output logic [lfp_pkg::FLAG_W-1:0]       open_led_flag_bits,
   output logic [lfp_pkg::FLAG_W-1:0]       open_trace_flag_bits,
   output logic [lfp_pkg::PHASE_W-1:0]      driver0_phase_select,
   output logic                             bcast_valid,
   output lfp_pkg::lfp_bcast_s              bcast
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic wr_led;
   logic wr_trace;
   logic wr_grp;
   logic wr_drv0;
   logic grp_valid;
   logic drv0_hit;
   logic [lfp_pkg::GRP_W-1:0]   wr_grp_sel;
   logic [lfp_pkg::PHASE_W-1:0] wr_phase;
   logic [lfp_pkg::FLAG_W-1:0]  wr_flags;

   assign wr_led   = reg_req.wr && (reg_req.addr == lfp_pkg::OFS_OPEN_LED);
   assign wr_trace = reg_req.wr && (reg_req.addr == lfp_pkg::OFS_OPEN_TRACE);
   assign wr_grp   = reg_req.wr && (reg_req.addr == lfp_pkg::OFS_GRP_PHASE);
   assign wr_drv0  = reg_req.wr && (reg_req.addr == lfp_pkg::OFS_DRV0_PHASE);

   assign wr_grp_sel = reg_req.wdata[lfp_pkg::GRP_SEL_LSB +: lfp_pkg::GRP_W];
   assign wr_phase   = reg_req.wdata[lfp_pkg::PHASE_LSB +: lfp_pkg::PHASE_W];
   assign wr_flags   = reg_req.wdata[lfp_pkg::FLAG_LSB +: lfp_pkg::FLAG_W];

   // An all-zero selection names no group, so nothing is sent
   assign grp_valid = wr_grp && (wr_grp_sel != lfp_pkg::GRP_SEL_NONE);

   // Driver 0 joins only when its own group is among those selected
   assign drv0_hit = grp_valid
      && ((wr_grp_sel[lfp_pkg::GRP_A_BIT] && group_a_assignment)
       || (wr_grp_sel[lfp_pkg::GRP_B_BIT] && group_b_assignment));

   // ----------------------------------------------------------------
   // Fault flag banks
   // ----------------------------------------------------------------
   lfp_flag_bank #(
      .W (lfp_pkg::FLAG_W)
   ) u_open_led (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .detect     (open_led_detect),
      .clear_en   (wr_led),
      .clear_mask (wr_flags),
      .flags      (open_led_flag_bits)
   );

   lfp_flag_bank #(
      .W (lfp_pkg::FLAG_W)
   ) u_open_trace (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .detect     (open_trace_detect),
      .clear_en   (wr_trace),
      .clear_mask (wr_flags),
      .flags      (open_trace_flag_bits)
   );

   // ----------------------------------------------------------------
   // Phase registers
   // ----------------------------------------------------------------
   logic [lfp_pkg::GRP_W-1:0]   grp_sel_reg;
   logic [lfp_pkg::GRP_W-1:0]   grp_sel_next;
   logic [lfp_pkg::PHASE_W-1:0] grp_phase_reg;
   logic [lfp_pkg::PHASE_W-1:0] grp_phase_next;
   logic [lfp_pkg::PHASE_W-1:0] drv0_reg;
   logic [lfp_pkg::PHASE_W-1:0] drv0_next;
   logic                        bvalid_reg;
   logic                        bvalid_next;
   lfp_pkg::lfp_bcast_s         bcast_reg;
   lfp_pkg::lfp_bcast_s         bcast_next;

   always_comb
   begin
      grp_sel_next   = grp_sel_reg;
      grp_phase_next = grp_phase_reg;
      drv0_next      = drv0_reg;
      bvalid_next    = 1'b0;
      bcast_next     = bcast_reg;
      if (wr_grp)
      begin
         grp_sel_next   = wr_grp_sel;
         grp_phase_next = wr_phase;
      end
      if (grp_valid)
      begin
         // Strobe lets the other per-driver registers take the value
         bvalid_next      = 1'b1;
         bcast_next.grp   = wr_grp_sel;
         bcast_next.phase = wr_phase;
      end
      if (wr_drv0)
      begin
         drv0_next = wr_phase;
      end
      else if (drv0_hit)
      begin
         drv0_next = wr_phase;
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         grp_sel_reg   <= lfp_pkg::GRP_SEL_RST;
         grp_phase_reg <= lfp_pkg::BCAST_PHASE_RST;
         drv0_reg      <= lfp_pkg::DRV0_PHASE_RST;
         bvalid_reg    <= 1'b0;
         bcast_reg     <= '0;
      end
      else
      begin
         grp_sel_reg   <= grp_sel_next;
         grp_phase_reg <= grp_phase_next;
         drv0_reg      <= drv0_next;
         bvalid_reg    <= bvalid_next;
         bcast_reg     <= bcast_next;
      end
   end

   assign driver0_phase_select = drv0_reg;
   assign bcast_valid          = bvalid_reg;
   assign bcast                = bcast_reg;

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Unmapped offsets read zero rather than holding stale data
   logic [lfp_pkg::DATA_W-1:0] rdata_reg;
   logic [lfp_pkg::DATA_W-1:0] rdata_next;
   logic                       rvalid_reg;
   logic                       rvalid_next;

   always_comb
   begin
      rdata_next  = rdata_reg;
      rvalid_next = reg_req.rd;
      if (reg_req.rd)
      begin
         rdata_next = '0;
         case (reg_req.addr)
            lfp_pkg::OFS_OPEN_LED:
               rdata_next[lfp_pkg::FLAG_LSB +: lfp_pkg::FLAG_W] =
                  open_led_flag_bits;
            lfp_pkg::OFS_OPEN_TRACE:
               rdata_next[lfp_pkg::FLAG_LSB +: lfp_pkg::FLAG_W] =
                  open_trace_flag_bits;
            lfp_pkg::OFS_GRP_PHASE:
            begin
               rdata_next[lfp_pkg::GRP_SEL_LSB +: lfp_pkg::GRP_W] =
                  grp_sel_reg;
               rdata_next[lfp_pkg::PHASE_LSB +: lfp_pkg::PHASE_W] =
                  grp_phase_reg;
            end
            lfp_pkg::OFS_DRV0_PHASE:
               rdata_next[lfp_pkg::PHASE_LSB +: lfp_pkg::PHASE_W] =
                  drv0_reg;
            default:
               rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdata_reg  <= lfp_pkg::RDATA_RST;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign reg_rdata  = rdata_reg;
   assign reg_rvalid = rvalid_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   chk_bcast_member: assert property (
      (grp_valid && drv0_hit) |=> (driver0_phase_select == $past(wr_phase)))
      else $error("member driver missed broadcast");

   chk_bcast_none: assert property (
      (wr_grp && (wr_grp_sel == lfp_pkg::GRP_SEL_NONE))
      |=> (!bcast_valid && $stable(driver0_phase_select)))
      else $error("empty selection broadcast");

   chk_bcast_nonmember: assert property (
      (grp_valid && !drv0_hit) |=> $stable(driver0_phase_select))
      else $error("non-member driver changed");

   chk_bcast_strobe: assert property (
      grp_valid |=> (bcast_valid && (bcast.phase == $past(wr_phase))
                     && (bcast.grp == $past(wr_grp_sel))))
      else $error("broadcast strobe wrong");

   chk_drv0_write: assert property (
      wr_drv0 |=> (driver0_phase_select == $past(wr_phase)))
      else $error("driver 0 write lost");

   chk_drv0_hold: assert property (
      (!wr_drv0 && !drv0_hit) |=> $stable(driver0_phase_select))
      else $error("driver 0 phase changed unasked");

   chk_led_read: assert property (
      (reg_req.rd && (reg_req.addr == lfp_pkg::OFS_OPEN_LED))
      |=> (reg_rvalid && (reg_rdata == {7'h00, $past(open_led_flag_bits)})))
      else $error("open-LED read data wrong");

   chk_trace_read: assert property (
      (reg_req.rd && (reg_req.addr == lfp_pkg::OFS_OPEN_TRACE))
      |=> (reg_rdata == {7'h00, $past(open_trace_flag_bits)}))
      else $error("open-trace read data wrong");

   chk_grp_read: assert property (
      (reg_req.rd && (reg_req.addr == lfp_pkg::OFS_GRP_PHASE))
      |=> (reg_rdata == {3'h0, $past(grp_sel_reg), $past(grp_phase_reg)}))
      else $error("group register read wrong");

   cov_bcast_both: cover property (
      grp_valid && (wr_grp_sel == 2'h3) && drv0_hit);
   cov_bcast_empty: cover property (
      wr_grp && (wr_grp_sel == lfp_pkg::GRP_SEL_NONE));
   cov_clear_race: cover property (
      wr_led && (|(wr_flags & open_led_detect)));
   cov_trace_clear: cover property (
      wr_trace && (|open_trace_flag_bits));

endmodule

`default_nettype wire
